// File: verilog/sc_tx_defs.svh
`ifndef SC_TX_DEFS_SVH
`define SC_TX_DEFS_SVH
// register byte offsets
`define OFF_ENABLE 8'h00
`define OFF_FORMAT 8'h04
`define OFF_THRESH 8'h08
`define OFF_GUARD 8'h0C
`define OFF_MASK 8'h10
`define OFF_STATUS 8'h14
`define OFF_TXDATA 8'h18
`define OFF_ETUDIV 8'h1C
// enable_reg fields
`define EN_TX_BIT 0
`define EN_PORT_BIT 1
// tx_threshold_reg fields
`define THR_LEVEL_LSB 0
`define THR_LIMIT_LSB 4
// status and mask bit positions
`define ST_THR_BIT 0
`define ST_ERR_BIT 1
`define ST_TC_BIT 2
`define ST_ETC_BIT 3
`define ST_EMPTY_BIT 4
`define ST_BLK_BIT 5
// reset values
`define MASK_RST 6'h3F
`define THRESH_RST 8'h00
`define GUARD_RST 8'h00
`define ETU_DIV_RST 16'h0174
// character shape
`define GUARD_ONE_STOP 8'hFF
`define DATA_BITS 4'h8
`define LAST_DATA_IDX 8'h07
`define FIFO_DEPTH 5'h10
`endif

// File: verilog/sc_tx_pkg.sv
package sc_tx_pkg;
    // transmit sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PARITY,
        ST_STOP
    } tx_state_t;
    // captured ahb address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } ahb_req_t;
    // sticky software-visible flags
    typedef struct packed {
        logic blk_end;
        logic early_done;
        logic done;
        logic retry_err;
        logic thr;
    } tx_flags_t;
endpackage

// File: verilog/smart_card_tx.sv
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "sc_tx_defs.svh"

module smart_card_tx (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // card data line, open drain
    input wire logic card_data_in,
    output logic card_data_out,
    output logic card_data_oe_n,
    // from the receiver
    input wire logic rx_convention_valid,
    input wire logic rx_convention_inverse,
    input wire logic rx_block_last,
    // interrupt request
    output logic irq
);
    // bus state
    sc_tx_pkg::ahb_req_t req_reg;
    logic [31:0] rdata_reg;
    // software registers
    logic tx_en_reg;
    logic port_en_reg;
    logic ic_reg;
    logic [7:0] thresh_reg;
    logic [7:0] guard_reg;
    logic [5:0] mask_reg;
    logic [15:0] etu_div_reg;
    sc_tx_pkg::tx_flags_t flags_reg;
    // fifo
    logic [7:0] fifo_mem [0:15];
    logic [3:0] wr_ptr_reg;
    logic [3:0] rd_ptr_reg;
    logic [4:0] count_reg;
    // sequencer
    sc_tx_pkg::tx_state_t state_reg;
    logic [15:0] etu_cnt_reg;
    logic [7:0] bit_idx_reg;
    logic [7:0] char_reg;
    logic [3:0] nack_cnt_reg;
    logic nack_seen_reg;
    logic line_reg;
    logic tx_en_d_reg;
    // synchroniser on the card line
    logic din_meta_reg;
    logic din_sync_reg;
    // decoded strobes
    logic wr_phase;
    logic push;
    logic pop;
    logic flush;
    logic etu_tick;
    logic last_stop;
    logic err_set;
    logic nack_now;
    logic [3:0] level;
    logic [3:0] limit;
    logic [7:0] stop_last_idx;
    logic [5:0] st_clr;
    logic [5:0] st_vec;

    // register match on the captured address
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // one bit of the serial character in the chosen convention
    function automatic logic char_bit(input logic [7:0] d, input logic [3:0] i,
                                      input logic inv);
        logic b;
        b = 1'b0;
        if (inv) begin
            b = ~d[3'h7 - i[2:0]];
        end else begin
            b = d[i[2:0]];
        end
        char_bit = b;
    endfunction

    assign level = thresh_reg[`THR_LEVEL_LSB +: 4];
    assign limit = thresh_reg[`THR_LIMIT_LSB +: 4];
    // always ready, always okay: zero wait states
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign wr_phase = req_reg.valid && req_reg.write;

    // ahb address phase capture
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_reg <= '0;
        end else if (hready) begin
            req_reg.valid <= hsel && htrans[1];
            req_reg.write <= hwrite;
            req_reg.addr <= haddr[7:0];
        end
    end

    // status as software sees it; fifo-empty is a live level
    assign st_vec = {flags_reg.blk_end, (count_reg == 5'h00), flags_reg.early_done,
                     flags_reg.done, flags_reg.retry_err, flags_reg.thr};

    // read data sampled at the address phase, unmapped reads zero
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                `OFF_ENABLE: rdata_reg <= {30'h0, port_en_reg, tx_en_reg};
                `OFF_FORMAT: rdata_reg <= {31'h0, ic_reg};
                `OFF_THRESH: rdata_reg <= {24'h0, thresh_reg};
                `OFF_GUARD: rdata_reg <= {24'h0, guard_reg};
                `OFF_MASK: rdata_reg <= {26'h0, mask_reg};
                `OFF_STATUS: rdata_reg <= {26'h0, st_vec};
                `OFF_TXDATA: rdata_reg <= {27'h0, count_reg};
                `OFF_ETUDIV: rdata_reg <= {16'h0, etu_div_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // plain control registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_en_reg <= 1'b0;
            port_en_reg <= 1'b0;
            thresh_reg <= `THRESH_RST;
            guard_reg <= `GUARD_RST;
            mask_reg <= `MASK_RST;
            etu_div_reg <= `ETU_DIV_RST;
        end else if (wr_phase) begin
            if (hit(req_reg.addr, `OFF_ENABLE)) begin
                tx_en_reg <= hwdata[`EN_TX_BIT];
                port_en_reg <= hwdata[`EN_PORT_BIT];
            end
            if (hit(req_reg.addr, `OFF_THRESH)) begin
                thresh_reg <= hwdata[7:0];
            end
            if (hit(req_reg.addr, `OFF_GUARD)) begin
                guard_reg <= hwdata[7:0];
            end
            if (hit(req_reg.addr, `OFF_MASK)) begin
                mask_reg <= hwdata[5:0];
            end
            // zero would stretch the etu timer to 65536 cycles, so it is clamped to one
            if (hit(req_reg.addr, `OFF_ETUDIV)) begin
                etu_div_reg <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
            end
        end
    end

    // convention bit: receiver update wins over a software write
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ic_reg <= 1'b0;
        end else if (rx_convention_valid) begin
            ic_reg <= rx_convention_inverse;
        end else if (wr_phase && hit(req_reg.addr, `OFF_FORMAT)) begin
            ic_reg <= hwdata[0];
        end
    end

    // card line synchroniser, two flops before any use
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            din_meta_reg <= 1'b1;
            din_sync_reg <= 1'b1;
        end else begin
            din_meta_reg <= card_data_in;
            din_sync_reg <= din_meta_reg;
        end
    end

    // fifo strobes; full fifo silently drops a write
    assign push = wr_phase && hit(req_reg.addr, `OFF_TXDATA) &&
                  (count_reg != `FIFO_DEPTH);
    assign pop = (state_reg == sc_tx_pkg::ST_IDLE) && tx_en_reg &&
                 !flags_reg.retry_err && (count_reg != 5'h00);
    // flush on enable falling or on the retry error
    assign flush = (tx_en_d_reg && !tx_en_reg) || err_set;

    // fifo storage
    always_ff @(posedge core_clk) begin
        if (push) begin
            fifo_mem[wr_ptr_reg] <= hwdata[7:0];
        end
    end

    // fifo pointers and fill level
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            count_reg <= 5'h00;
        end else if (flush) begin
            // a write landing in the flush cycle is lost with the rest
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            count_reg <= 5'h00;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 4'h1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 4'h1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 5'h01;
            end else if (pop && !push) begin
                count_reg <= count_reg - 5'h01;
            end
        end
    end

    // etu timer; restarts with each character
    assign etu_tick = (state_reg != sc_tx_pkg::ST_IDLE) &&
                      (etu_cnt_reg == etu_div_reg - 16'h0001);
    // stop phase: two bits plus guard, or one bit for guard ff
    assign stop_last_idx = (guard_reg == `GUARD_ONE_STOP) ? 8'h00 :
                           guard_reg + 8'h01;
    assign last_stop = (state_reg == sc_tx_pkg::ST_STOP) && etu_tick &&
                       (bit_idx_reg == stop_last_idx);
    // sample the line at the end of the first stop etu
    assign nack_now = (state_reg == sc_tx_pkg::ST_STOP) && etu_tick &&
                      (bit_idx_reg == 8'h00) && !din_sync_reg &&
                      (limit != 4'h0);
    assign err_set = last_stop && nack_seen_reg &&
                     (nack_cnt_reg + 4'h1 >= limit);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_en_d_reg <= 1'b0;
        end else begin
            tx_en_d_reg <= tx_en_reg;
        end
    end

    // transmit sequencer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= sc_tx_pkg::ST_IDLE;
            etu_cnt_reg <= 16'h0000;
            bit_idx_reg <= 8'h00;
            char_reg <= 8'h00;
            nack_cnt_reg <= 4'h0;
            nack_seen_reg <= 1'b0;
        end else if (!tx_en_reg) begin
            state_reg <= sc_tx_pkg::ST_IDLE;
            etu_cnt_reg <= 16'h0000;
            nack_cnt_reg <= 4'h0;
            nack_seen_reg <= 1'b0;
        end else begin
            etu_cnt_reg <= (etu_tick || state_reg == sc_tx_pkg::ST_IDLE) ? 16'h0000 :
                           etu_cnt_reg + 16'h0001;
            if (nack_now) begin
                nack_seen_reg <= 1'b1;
            end
            unique case (state_reg)
                sc_tx_pkg::ST_IDLE: begin
                    // start state follows the pop by one cycle, the start bit on the line by two
                    if (pop) begin
                        char_reg <= fifo_mem[rd_ptr_reg];
                        state_reg <= sc_tx_pkg::ST_START;
                    end
                end
                sc_tx_pkg::ST_START: begin
                    if (etu_tick) begin
                        bit_idx_reg <= 8'h00;
                        state_reg <= sc_tx_pkg::ST_DATA;
                    end
                end
                sc_tx_pkg::ST_DATA: begin
                    if (etu_tick) begin
                        bit_idx_reg <= bit_idx_reg + 8'h01;
                        if (bit_idx_reg == `LAST_DATA_IDX) begin
                            state_reg <= sc_tx_pkg::ST_PARITY;
                        end
                    end
                end
                sc_tx_pkg::ST_PARITY: begin
                    if (etu_tick) begin
                        bit_idx_reg <= 8'h00;
                        state_reg <= sc_tx_pkg::ST_STOP;
                    end
                end
                sc_tx_pkg::ST_STOP: begin
                    if (etu_tick) begin
                        bit_idx_reg <= bit_idx_reg + 8'h01;
                    end
                    if (last_stop) begin
                        nack_seen_reg <= 1'b0;
                        if (err_set) begin
                            // give up on this byte; no retry
                            nack_cnt_reg <= 4'h0;
                            state_reg <= sc_tx_pkg::ST_IDLE;
                        end else if (nack_seen_reg) begin
                            // same byte again, held in char_reg
                            nack_cnt_reg <= nack_cnt_reg + 4'h1;
                            state_reg <= sc_tx_pkg::ST_START;
                        end else begin
                            nack_cnt_reg <= 4'h0;
                            state_reg <= sc_tx_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // serial line level; one is released
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            line_reg <= 1'b1;
        end else begin
            unique case (state_reg)
                sc_tx_pkg::ST_START: line_reg <= 1'b0;
                sc_tx_pkg::ST_DATA: line_reg <= char_bit(char_reg, bit_idx_reg[3:0], ic_reg);
                // even parity, inverted with the data in inverse mode
                sc_tx_pkg::ST_PARITY: line_reg <= (^char_reg) ^ ic_reg;
                default: line_reg <= 1'b1;
            endcase
        end
    end
    // open drain: only pull low, and only with the port enabled
    assign card_data_out = 1'b0;
    assign card_data_oe_n = line_reg || !port_en_reg;

    // write-one-to-clear strobes
    assign st_clr = (wr_phase && hit(req_reg.addr, `OFF_STATUS)) ? hwdata[5:0] : 6'h00;

    // sticky flags; a set in the clear cycle wins
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_reg <= '0;
        end else begin
            if (count_reg[3:0] <= level && !count_reg[4]) begin
                flags_reg.thr <= 1'b1;
            end else if (st_clr[`ST_THR_BIT]) begin
                flags_reg.thr <= 1'b0;
            end
            if (err_set) begin
                flags_reg.retry_err <= 1'b1;
            end else if (st_clr[`ST_ERR_BIT]) begin
                flags_reg.retry_err <= 1'b0;
            end
            if (err_set || (last_stop && !nack_seen_reg && count_reg == 5'h00)) begin
                flags_reg.done <= 1'b1;
            end else if (st_clr[`ST_TC_BIT]) begin
                flags_reg.done <= 1'b0;
            end
            // early completion once the last byte reaches its stop bits
            if (err_set || (state_reg == sc_tx_pkg::ST_PARITY && etu_tick &&
                            count_reg == 5'h00)) begin
                flags_reg.early_done <= 1'b1;
            end else if (st_clr[`ST_ETC_BIT]) begin
                flags_reg.early_done <= 1'b0;
            end
            if (rx_block_last) begin
                flags_reg.blk_end <= 1'b1;
            end else if (st_clr[`ST_BLK_BIT]) begin
                flags_reg.blk_end <= 1'b0;
            end
        end
    end

    // interrupt: any flag whose mask bit is clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(st_vec & ~mask_reg);
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_enable_with_data;
        !tx_en_d_reg && tx_en_reg && count_reg != 5'h00 && !flags_reg.retry_err &&
        state_reg == sc_tx_pkg::ST_IDLE;
    endsequence

    a_start_prompt: assert property (s_enable_with_data |-> ##1 state_reg == sc_tx_pkg::ST_START ##1 !line_reg)
        else $error("start bit not sent promptly");
    a_disable_flush: assert property (tx_en_d_reg && !tx_en_reg |=> count_reg == 5'h00 && state_reg == sc_tx_pkg::ST_IDLE)
        else $error("disable did not flush");
    a_thr_sets: assert property (count_reg[3:0] <= level && !count_reg[4] |=> flags_reg.thr)
        else $error("threshold flag not set");
    a_thr_sticky: assert property (flags_reg.thr && !st_clr[`ST_THR_BIT] |=> flags_reg.thr)
        else $error("threshold flag dropped");
    a_irq_gate: assert property (flags_reg.thr && !mask_reg[`ST_THR_BIT] |=> irq)
        else $error("threshold interrupt missing");
    a_err_effects: assert property (err_set |=> flags_reg.retry_err && flags_reg.done && flags_reg.early_done && count_reg == 5'h00)
        else $error("retry error effects missing");
    a_err_frozen: assert property (flags_reg.retry_err && state_reg == sc_tx_pkg::ST_IDLE |=> state_reg == sc_tx_pkg::ST_IDLE)
        else $error("transmitter left freeze");
    a_nack_off: assert property (limit == 4'h0 |-> !nack_now && !err_set)
        else $error("nack seen with detection off");
    a_parity_even: assert property (state_reg == sc_tx_pkg::ST_PARITY && !ic_reg |=> line_reg == ^char_reg)
        else $error("parity bit wrong");
endmodule // smart_card_tx

// File: sim/card_model.sv
`timescale 1ns/1ps
// behavioural card: decodes each frame, can answer with a nack
module card_model #(
    parameter int ETU = 16
) (
    // clock and resolved line
    input wire logic core_clk,
    input wire logic line,
    // bench asks for a nack on every frame
    input wire logic nack_on,
    // high pulls the line low
    output logic pull_low
);
    logic [8:0] frames [$]; // data bits then parity, line levels
    int starts [$]; // cycle of each start bit seen
    int cyc = 0; // free running cycle count
    // cycle count for start times
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
    end
    // decoder samples mid bit; resumes at 10.5 etu, or 11.5 etu after a nack, so 11 etu chars are not missed
    initial begin
        logic [8:0] f;
        pull_low = 1'b0;
        forever begin
            @(posedge core_clk);
            if (line === 1'b0) begin
                starts.push_back(cyc);
                repeat (ETU / 2) @(posedge core_clk);
                for (int i = 0; i < 9; i++) begin
                    repeat (ETU) @(posedge core_clk);
                    f[i] = line;
                end
                frames.push_back(f);
                repeat (ETU) @(posedge core_clk);
                // low from 10.5 to 11.5 etu in the stop bit
                if (nack_on) begin
                    pull_low <= 1'b1;
                    repeat (ETU) @(posedge core_clk);
                    pull_low <= 1'b0;
                end
            end
        end
    end
endmodule // card_model

// File: sim/smart_card_transmitter_tb_top.sv
`timescale 1ns/1ps
`include "sc_tx_defs.svh"
// register calls over ahb-lite, card model on the line
module smart_card_transmitter_tb_top;
    localparam int E = 16; // short etu keeps the run brief
    localparam logic [7:0] ST = `OFF_STATUS;
    localparam logic [7:0] TH = `OFF_THRESH;
    localparam logic [7:0] TX = `OFF_TXDATA;
    localparam logic [7:0] MK = `OFF_MASK;
    localparam logic [7:0] GD [3] = '{8'h03, 8'hFF, 8'h00}; // guard cases
    localparam int LM [3] = '{0, 1, 3}; // nack limit cases
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    // ahb master side
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    // line and receiver side
    logic card_data_out;
    logic card_data_oe_n;
    logic pull_low;
    logic nack_on = 1'b0;
    logic rx_convention_valid = 1'b0;
    logic rx_convention_inverse = 1'b0;
    logic rx_block_last = 1'b0;
    logic irq;
    // open drain with pull-up, either party may pull low
    wire logic line = (card_data_oe_n ? 1'b1 : card_data_out) & ~pull_low;
    int failures = 0;
    int check_count = 0;
    // 100 mhz clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    smart_card_tx i_dut (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .card_data_in(line),
        .card_data_out, .card_data_oe_n, .rx_convention_valid, .rx_convention_inverse,
        .rx_block_last, .irq);
    card_model #(.ETU(E)) i_card (.core_clk, .line, .nack_on, .pull_low);
    // verdict and end of run
    task automatic close_out();
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // single transfer: address phase, then data phase, each held until hready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        for (int ph = 0; ph < 2; ph++) begin
            if (ph == 1) begin
                hsel <= 1'b0;
                htrans <= 2'h0;
                hwdata <= d;
            end
            n = 0;
            do begin
                @(posedge core_clk);
                n++;
            end while (hreadyout !== 1'b1 && n < 64);
            if (n >= 64) begin
                failures++;
                close_out();
            end
        end
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    // read, mask and compare
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask
    // bounded wait for the card to decode k frames
    task automatic wait_frames(input int k);
        int n;
        n = 0;
        while (i_card.frames.size() < k && n < 20000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 20000) begin
            failures++;
            close_out();
        end
    endtask
    // expected line bits: even parity, inverse reverses and inverts
    function automatic logic [8:0] enc(input logic [7:0] d, input logic inv);
        logic [8:0] f;
        f = {^d, d};
        if (inv) begin
            for (int i = 0; i < 8; i++) begin
                f[i] = ~d[7 - i];
            end
            f[8] = ~^d;
        end
        return f;
    endfunction
    // main sequence
    initial begin
        int n0;
        int k;
        int t0;
        int sp;
        ticks(10);
        sys_rst <= 1'b0;
        rc(8'h40, 32'hFFFFFFFF, 32'h0);
        rc(MK, 32'hFF, 32'h3F);
        wr(`OFF_ETUDIV, E);
        // receiver events
        rx_block_last <= 1'b1;
        rx_convention_valid <= 1'b1;
        rx_convention_inverse <= 1'b1;
        ticks(1);
        rx_block_last <= 1'b0;
        rx_convention_valid <= 1'b0;
        rc(ST, 32'h20, 32'h20);
        rc(`OFF_FORMAT, 32'h1, 32'h1);
        wr(MK, 32'h1F);
        ticks(2);
        chk(irq, 1'b1);
        wr(ST, 32'h20);
        wr(`OFF_FORMAT, 32'h0);
        // six bytes queued while disabled, threshold moves
        for (int i = 0; i < 6; i++) begin
            wr(TX, 32'h30 + i);
        end
        wr(TH, 32'h5);
        wr(ST, 32'h1);
        rc(ST, 32'h1, 32'h0);
        wr(TH, 32'h6);
        // flag is a flop: it follows the new level one edge later
        ticks(1);
        rc(ST, 32'h1, 32'h1);
        wr(TH, 32'h5);
        rc(ST, 32'h1, 32'h1);
        wr(MK, 32'h3E);
        ticks(2);
        chk(irq, 1'b1);
        wr(MK, 32'h3F);
        ticks(2);
        chk(irq, 1'b0);
        wr(ST, 32'h1);
        rc(ST, 32'h1, 32'h0);
        wr(TH, 32'h0);
        // fill past sixteen: the extra byte is dropped
        for (int i = 6; i < 17; i++) begin
            wr(TX, 32'h30 + i);
        end
        rc(TX, 32'h1F, 32'h10);
        chk(hresp, 1'b0);
        n0 = i_card.frames.size();
        wr(`OFF_ENABLE, 32'h3);
        t0 = i_card.cyc;
        wait_frames(n0 + 16);
        chk(i_card.starts[n0] - t0 <= 2 * E, 1);
        chk(i_card.frames[n0], enc(8'h30, 1'b0));
        for (int i = 1; i < 16; i++) begin
            sp = i_card.starts[n0 + i] - i_card.starts[n0 + i - 1];
            chk(i_card.frames[n0 + i], enc(8'(8'h30 + i), 1'b0));
            chk(sp >= 12 * E && sp <= 12 * E + 3, 1);
        end
        ticks(3 * E);
        rc(ST, 32'h1, 32'h1);
        // guard and convention cases, bytes pushed into an empty enabled fifo
        for (int c = 0; c < 3; c++) begin
            wr(`OFF_FORMAT, {31'h0, c < 2});
            wr(`OFF_GUARD, {24'h0, GD[c]});
            n0 = i_card.frames.size();
            ticks(2 * E);
            chk(i_card.frames.size(), n0);
            wr(TX, 32'hA5);
            wr(TX, 32'h3C + c);
            wait_frames(n0 + 2);
            sp = i_card.starts[n0 + 1] - i_card.starts[n0];
            k = (GD[c] == 8'hFF) ? 11 * E : (12 + int'(GD[c])) * E;
            chk(i_card.frames[n0 + 1], enc(8'(8'h3C + c), c < 2));
            chk(sp >= k && sp <= k + 3, 1);
        end
        // card nacks every frame but the 96 recovery byte; limits 0, 1 and 3
        wr(`OFF_GUARD, 32'h0);
        wr(`OFF_FORMAT, 32'h0);
        ticks(3 * E);
        nack_on <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wr(TH, LM[c] << 4);
            wr(ST, 32'h3F);
            n0 = i_card.frames.size();
            wr(TX, 32'h5A);
            wr(TX, 32'h69);
            k = (LM[c] == 0) ? 2 : LM[c];
            wait_frames(n0 + k);
            ticks(14 * E);
            chk(i_card.frames.size() - n0, k);
            chk(i_card.frames[n0 + k - 1], enc(LM[c] == 0 ? 8'h69 : 8'h5A, 1'b0));
            rc(ST, 32'h2, LM[c] == 0 ? 32'h0 : 32'h2);
            if (LM[c] != 0) begin
                rc(ST, 32'h1C, 32'h1C);
                rc(TX, 32'h1F, 32'h0);
                wr(MK, 32'h3D);
                ticks(2);
                chk(irq, 1'b1);
                wr(MK, 32'h3F);
                nack_on <= 1'b0;
                wr(TX, 32'h96);
                ticks(14 * E);
                chk(i_card.frames.size() - n0, k);
                wr(ST, 32'h2);
                wait_frames(n0 + k + 1);
                ticks(14 * E);
                // card stays quiet after the last limit case
                nack_on <= (c < 2);
            end
        end
        // disable in mid character
        for (int i = 0; i < 3; i++) begin
            wr(TX, 32'hC3);
        end
        ticks(3 * E);
        wr(`OFF_ENABLE, 32'h2);
        // sequencer idles one edge after the write, the line flop one more
        ticks(3);
        chk(card_data_oe_n, 1'b1);
        rc(TX, 32'h1F, 32'h0);
        close_out();
    end
endmodule // smart_card_transmitter_tb_top
